/* File: mdda_regs.svh */
`ifndef MDDA_REGS_SVH
`define MDDA_REGS_SVH
`define MDDA_DIV_BYTE_STEPS 8
`define MDDA_DIV_WORD_STEPS 16
`define MDDA_FLAG_N 3
`define MDDA_FLAG_Z 2
`define MDDA_FLAG_V 1
`define MDDA_FLAG_C 0
`define MDDA_FLAG_H 4
`define MDDA_FLAGS_RESET 8'h00
`endif

/* File: mdda_pkg.sv */
package mdda_pkg;
	typedef enum logic [3:0] {
		MDDA_OP_NONE,
		MDDA_OP_UNSIGNED_EXTENDED_MULTIPLY,
		MDDA_OP_SIGNED_EXTENDED_MULTIPLY,
		MDDA_OP_UNSIGNED_EXTENDED_DIVIDE,
		MDDA_OP_SIGNED_EXTENDED_DIVIDE,
		MDDA_OP_DECIMAL_ADJUST_AFTER_SUBTRACT,
		MDDA_OP_LONG_DECREMENT,
		MDDA_OP_COMPARE_OP
	} mdda_op_t;
	typedef enum logic [1:0] {
		MDDA_SZ_BYTE,
		MDDA_SZ_WORD,
		MDDA_SZ_LONG
	} mdda_size_t;
	typedef struct packed {
		mdda_op_t op;
		mdda_size_t size;
		logic dec_two;
		logic [31:0] dst;
		logic [31:0] src;
		logic in_h;
		logic in_c;
	} mdda_req_t;
	typedef struct packed {
		logic [31:0] result;
		logic write_en;
		logic [7:0] flags;
	} mdda_rsp_t;
endpackage

/* File: mdda_divider.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mdda_regs.svh"
// restoring divider, one quotient bit per cycle; unsigned magnitudes only
module mdda_divider (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic word_size,
	input wire logic [31:0] dividend,
	input wire logic [15:0] divisor,
	output logic done,
	output logic [15:0] quotient,
	output logic [15:0] remainder
);
	logic [16:0] rem;
	logic [31:0] shreg;
	logic [15:0] dvs;
	logic [4:0] count;
	logic busy;
	logic [16:0] trial;
	logic [16:0] shifted;

	always_comb begin
		shifted = {rem[15:0], shreg[31]};
		trial = shifted - {1'b0, dvs};
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			busy <= 1'b0;
			done <= 1'b0;
			count <= 5'h00;
			rem <= 17'h00000;
			shreg <= 32'h00000000;
			dvs <= 16'h0000;
		end else begin
			done <= 1'b0;
			if (start) begin
				busy <= 1'b1;
				dvs <= divisor;
				// byte form: dividend sits in low 16 bits, left-justify it
				// word form: high half preloads the remainder, so the quotient must fit 16 bits
				if (word_size) begin
					rem <= {1'b0, dividend[31:16]};
					shreg <= {dividend[15:0], 16'h0000};
					count <= 5'(`MDDA_DIV_WORD_STEPS);
				end else begin
					rem <= 17'h00000;
					shreg <= {dividend[15:0], 16'h0000};
					count <= 5'(`MDDA_DIV_BYTE_STEPS * 2);
				end
			end else if (busy) begin
				if (trial[16]) begin
					rem <= shifted;
					shreg <= {shreg[30:0], 1'b0};
				end else begin
					rem <= trial;
					shreg <= {shreg[30:0], 1'b1};
				end
				count <= count - 5'h01;
				if (count == 5'h01) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

	assign quotient = shreg[15:0];
	assign remainder = rem[15:0];
endmodule // mdda_divider
`default_nettype wire

/* File: mdda_alu.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mdda_regs.svh"
// Summary of operation
// - byte unsigned multiply, 16-bit product to destination
// - word unsigned multiply, 32-bit product to whole destination
// - byte signed multiply, 16-bit signed product
// - word signed multiply, 32-bit signed product
// - byte unsigned divide: remainder high, quotient low
// - word unsigned divide: remainder high half, quotient low
// - byte signed divide: remainder high, quotient low
// - word signed divide: remainder high, quotient low
// - decimal adjust subtraction result into packed BCD
module mdda_alu (
	input wire logic clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire mdda_pkg::mdda_req_t req,
	output logic busy,
	output logic rsp_valid,
	output mdda_pkg::mdda_rsp_t rsp
);
	typedef enum {ST_IDLE, ST_DIV} mdda_state_t;
	mdda_state_t state;
	mdda_pkg::mdda_req_t held;
	logic div_start;
	logic div_done;
	logic [15:0] div_q;
	logic [15:0] div_r;
	logic [31:0] div_dividend;
	logic [15:0] div_divisor;
	logic next_rsp_valid;
	mdda_pkg::mdda_rsp_t next_rsp;

	function automatic logic [31:0] mag32(input logic [31:0] v, input logic neg);
		mag32 = neg ? 32'(-v) : v;
	endfunction

	function automatic logic [7:0] nz_flags(input logic neg, input logic zero);
		nz_flags = 8'h00;
		nz_flags[`MDDA_FLAG_N] = neg;
		nz_flags[`MDDA_FLAG_Z] = zero;
	endfunction

	logic req_word;
	logic dvd_neg;
	logic dvs_neg;
	logic is_signed_div;
	assign req_word = (req.size != mdda_pkg::MDDA_SZ_BYTE);
	assign is_signed_div = (req.op == mdda_pkg::MDDA_OP_SIGNED_EXTENDED_DIVIDE);
	assign dvd_neg = is_signed_div & (req_word ? req.dst[31] : req.dst[15]);
	assign dvs_neg = is_signed_div & (req_word ? req.src[15] : req.src[7]);

	// divider sees magnitudes; signs are reapplied when it finishes
	// low bits of a negation ignore the bits above, so a mask is enough
	assign div_dividend = mag32(req_word ? req.dst : {16'h0000, req.dst[15:0]}, dvd_neg)
		& (req_word ? 32'hFFFFFFFF : 32'h0000FFFF);
	assign div_divisor = 16'(mag32({16'h0000, req.src[15:0]}, dvs_neg)
		& (req_word ? 32'h0000FFFF : 32'h000000FF));
	assign div_start = req_valid && (state == ST_IDLE) && (req.op == mdda_pkg::MDDA_OP_UNSIGNED_EXTENDED_DIVIDE
		|| req.op == mdda_pkg::MDDA_OP_SIGNED_EXTENDED_DIVIDE);

	mdda_divider u_div (
		.clk(clk),
		.reset(reset),
		.start(div_start),
		.word_size(req_word),
		.dividend(div_dividend),
		.divisor(div_divisor),
		.done(div_done),
		.quotient(div_q),
		.remainder(div_r)
	);

	logic h_dvd_neg;
	logic h_dvs_neg;
	logic h_word;
	assign h_word = (held.size != mdda_pkg::MDDA_SZ_BYTE);
	assign h_dvd_neg = (held.op == mdda_pkg::MDDA_OP_SIGNED_EXTENDED_DIVIDE) & (h_word ? held.dst[31] : held.dst[15]);
	assign h_dvs_neg = (held.op == mdda_pkg::MDDA_OP_SIGNED_EXTENDED_DIVIDE) & (h_word ? held.src[15] : held.src[7]);

	always_comb begin
		logic [31:0] p;
		logic [32:0] diff;
		logic [7:0] adj;
		logic [15:0] q;
		logic [15:0] r;
		p = 32'h00000000;
		diff = 33'h000000000;
		adj = 8'h00;
		q = 16'h0000;
		r = 16'h0000;
		next_rsp_valid = 1'b0;
		next_rsp = '0;
		if (state == ST_DIV && div_done) begin
			next_rsp_valid = 1'b1;
			next_rsp.write_en = 1'b1;
			// quotient negative when signs differ, remainder follows dividend
			q = (h_dvd_neg ^ h_dvs_neg) ? 16'(-div_q) : div_q;
			r = h_dvd_neg ? 16'(-div_r) : div_r;
			if (h_word) begin
				next_rsp.result = {r, q};
				next_rsp.flags = nz_flags(q[15], held.src[15:0] == 16'h0000);
			end else begin
				next_rsp.result = {held.dst[31:16], r[7:0], q[7:0]};
				next_rsp.flags = nz_flags(q[7], held.src[7:0] == 8'h00);
			end
		end else if (req_valid && state == ST_IDLE) begin
			next_rsp_valid = 1'b1;
			next_rsp.write_en = 1'b1;
			case (req.op)
				mdda_pkg::MDDA_OP_UNSIGNED_EXTENDED_MULTIPLY: begin
					if (req_word) begin
						next_rsp.result = req.dst[15:0] * req.src[15:0];
					end else begin
						p[15:0] = req.dst[7:0] * req.src[7:0];
						next_rsp.result = {req.dst[31:16], p[15:0]};
					end
				end
				mdda_pkg::MDDA_OP_SIGNED_EXTENDED_MULTIPLY: begin
					if (req_word) begin
						p = 32'($signed(req.dst[15:0]) * $signed(req.src[15:0]));
						next_rsp.result = p;
						next_rsp.flags = nz_flags(p[31], p == 32'h00000000);
					end else begin
						p[15:0] = 16'($signed(req.dst[7:0]) * $signed(req.src[7:0]));
						next_rsp.result = {req.dst[31:16], p[15:0]};
						next_rsp.flags = nz_flags(p[15], p[15:0] == 16'h0000);
					end
				end
				mdda_pkg::MDDA_OP_DECIMAL_ADJUST_AFTER_SUBTRACT: begin
					// borrow flags from the preceding subtraction pick the correction
					adj = req.dst[7:0];
					if (req.in_h) adj = adj + 8'hFA;
					if (req.in_c) adj = adj + 8'hA0;
					next_rsp.result = {req.dst[31:8], adj};
					next_rsp.flags = nz_flags(adj[7], adj == 8'h00);
					next_rsp.flags[`MDDA_FLAG_C] = req.in_c;
				end
				mdda_pkg::MDDA_OP_LONG_DECREMENT: begin
					diff = {1'b0, req.dst} - (req.dec_two ? 33'h000000002 : 33'h000000001);
					next_rsp.result = diff[31:0];
					next_rsp.flags = nz_flags(diff[31], diff[31:0] == 32'h00000000);
					next_rsp.flags[`MDDA_FLAG_V] = req.dst[31] & ~diff[31];
				end
				mdda_pkg::MDDA_OP_COMPARE_OP: begin
					next_rsp.write_en = 1'b0;
					next_rsp.result = req.dst;
					case (req.size)
						mdda_pkg::MDDA_SZ_BYTE: begin
							diff = {25'h0000000, req.dst[7:0]} - {25'h0000000, req.src[7:0]};
							next_rsp.flags = nz_flags(diff[7], diff[7:0] == 8'h00);
							next_rsp.flags[`MDDA_FLAG_C] = diff[8];
							next_rsp.flags[`MDDA_FLAG_V] = (req.dst[7] ^ req.src[7]) & (req.dst[7] ^ diff[7]);
							next_rsp.flags[`MDDA_FLAG_H] = req.dst[3:0] < req.src[3:0];
						end
						mdda_pkg::MDDA_SZ_WORD: begin
							diff = {17'h00000, req.dst[15:0]} - {17'h00000, req.src[15:0]};
							next_rsp.flags = nz_flags(diff[15], diff[15:0] == 16'h0000);
							next_rsp.flags[`MDDA_FLAG_C] = diff[16];
							next_rsp.flags[`MDDA_FLAG_V] = (req.dst[15] ^ req.src[15]) & (req.dst[15] ^ diff[15]);
							next_rsp.flags[`MDDA_FLAG_H] = req.dst[11:0] < req.src[11:0];
						end
						default: begin
							diff = {1'b0, req.dst} - {1'b0, req.src};
							next_rsp.flags = nz_flags(diff[31], diff[31:0] == 32'h00000000);
							next_rsp.flags[`MDDA_FLAG_C] = diff[32];
							next_rsp.flags[`MDDA_FLAG_V] = (req.dst[31] ^ req.src[31]) & (req.dst[31] ^ diff[31]);
							next_rsp.flags[`MDDA_FLAG_H] = req.dst[27:0] < req.src[27:0];
						end
					endcase
				end
				default: begin
					// divide starts now and answers later; idle op answers nothing
					next_rsp_valid = 1'b0;
					next_rsp.write_en = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= ST_IDLE;
			held <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (div_start) begin
						state <= ST_DIV;
						held <= req;
					end
				end
				ST_DIV: begin
					if (div_done) state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rsp_valid <= 1'b0;
			rsp <= '0;
			busy <= 1'b0;
		end else begin
			rsp_valid <= next_rsp_valid;
			if (next_rsp_valid) rsp <= next_rsp;
			busy <= div_start | (state == ST_DIV && !div_done);
		end
	end

	property p_mul_byte;
		@(posedge clk) disable iff (reset)
		(req_valid && state == ST_IDLE && req.op == mdda_pkg::MDDA_OP_UNSIGNED_EXTENDED_MULTIPLY
			&& req.size == mdda_pkg::MDDA_SZ_BYTE)
		|=> rsp_valid && rsp.result[15:0] == 16'($past(req.dst[7:0]) * $past(req.src[7:0]));
	endproperty
	a_mul_byte: assert property (p_mul_byte) else $error("byte unsigned product wrong");

	property p_mul_word;
		@(posedge clk) disable iff (reset)
		(req_valid && state == ST_IDLE && req.op == mdda_pkg::MDDA_OP_UNSIGNED_EXTENDED_MULTIPLY
			&& req.size == mdda_pkg::MDDA_SZ_WORD)
		|=> rsp.result == 32'($past(req.dst[15:0]) * $past(req.src[15:0]));
	endproperty
	a_mul_word: assert property (p_mul_word) else $error("word unsigned product wrong");

	property p_smul_byte;
		@(posedge clk) disable iff (reset)
		(req_valid && state == ST_IDLE && req.op == mdda_pkg::MDDA_OP_SIGNED_EXTENDED_MULTIPLY
			&& req.size == mdda_pkg::MDDA_SZ_BYTE)
		|=> rsp.result[15:0] == 16'($signed($past(req.dst[7:0])) * $signed($past(req.src[7:0])));
	endproperty
	a_smul_byte: assert property (p_smul_byte) else $error("byte signed product wrong");

	property p_smul_word;
		@(posedge clk) disable iff (reset)
		(req_valid && state == ST_IDLE && req.op == mdda_pkg::MDDA_OP_SIGNED_EXTENDED_MULTIPLY
			&& req.size == mdda_pkg::MDDA_SZ_WORD)
		|=> rsp.result == 32'($signed($past(req.dst[15:0])) * $signed($past(req.src[15:0])));
	endproperty
	a_smul_word: assert property (p_smul_word) else $error("word signed product wrong");

	sequence s_div_begin;
		div_start && !req_word;
	endsequence
	property p_div_byte_time;
		@(posedge clk) disable iff (reset)
		s_div_begin |-> ##1 busy ##[1:20] rsp_valid;
	endproperty
	a_div_byte_time: assert property (p_div_byte_time) else $error("byte divide never answered");

	property p_udiv_word;
		@(posedge clk) disable iff (reset)
		(state == ST_DIV && div_done && held.op == mdda_pkg::MDDA_OP_UNSIGNED_EXTENDED_DIVIDE && h_word
			&& held.src[15:0] != 16'h0000)
		|=> rsp.result[15:0] == 16'($past(held.dst) / $past(held.src[15:0]))
			&& rsp.result[31:16] == 16'($past(held.dst) % $past(held.src[15:0]));
	endproperty
	a_udiv_word: assert property (p_udiv_word) else $error("word unsigned quotient wrong");

	property p_sdiv_sign;
		@(posedge clk) disable iff (reset)
		(state == ST_DIV && div_done && h_word && (h_dvd_neg ^ h_dvs_neg) && div_q != 16'h0000)
		|=> rsp.result[15];
	endproperty
	a_sdiv_sign: assert property (p_sdiv_sign) else $error("signed quotient sign wrong");

	property p_sdiv_byte_rem;
		@(posedge clk) disable iff (reset)
		(state == ST_DIV && div_done && !h_word && h_dvd_neg && div_r != 16'h0000)
		|=> rsp.result[15];
	endproperty
	a_sdiv_byte_rem: assert property (p_sdiv_byte_rem) else $error("byte remainder sign wrong");

	property p_das_none;
		@(posedge clk) disable iff (reset)
		(req_valid && state == ST_IDLE && req.op == mdda_pkg::MDDA_OP_DECIMAL_ADJUST_AFTER_SUBTRACT
			&& !req.in_h && !req.in_c)
		|=> rsp.result[7:0] == $past(req.dst[7:0]);
	endproperty
	a_das_none: assert property (p_das_none) else $error("decimal adjust changed clean value");

	property p_dec;
		@(posedge clk) disable iff (reset)
		(req_valid && state == ST_IDLE && req.op == mdda_pkg::MDDA_OP_LONG_DECREMENT)
		|=> rsp.result == 32'($past(req.dst) - ($past(req.dec_two) ? 32'h00000002 : 32'h00000001));
	endproperty
	a_dec: assert property (p_dec) else $error("long decrement wrong");

	property p_cmp;
		@(posedge clk) disable iff (reset)
		(req_valid && state == ST_IDLE && req.op == mdda_pkg::MDDA_OP_COMPARE_OP)
		|=> rsp_valid && !rsp.write_en && rsp.flags[`MDDA_FLAG_Z] == ((($past(req.dst) ^ $past(req.src))
			& ($past(req.size) == mdda_pkg::MDDA_SZ_BYTE ? 32'h000000FF : $past(req.size) == mdda_pkg::MDDA_SZ_WORD
			? 32'h0000FFFF : 32'hFFFFFFFF)) == 32'h00000000);
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare wrote or flagged wrongly");
endmodule // mdda_alu
`default_nettype wire

/* File: mdda_regfile_model.sv */
`timescale 1ns/1ps
`default_nettype none
// destination register of the general register file, seen from the alu
module mdda_regfile_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic preset,
	input wire logic [31:0] preset_value,
	input wire logic rsp_valid,
	input wire mdda_pkg::mdda_rsp_t rsp,
	output logic [31:0] dest
);
	// writes back only when enabled, so a compare cannot disturb it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dest <= 32'h00000000;
		end else if (preset) begin
			dest <= preset_value;
		end else if (rsp_valid && rsp.write_en) begin
			dest <= rsp.result;
		end
	end
endmodule // mdda_regfile_model
`default_nettype wire

/* File: multiply_divide_decimal_alu_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mdda_regs.svh"
module multiply_divide_decimal_alu_tb_top;
	localparam mdda_pkg::mdda_op_t MU = mdda_pkg::MDDA_OP_UNSIGNED_EXTENDED_MULTIPLY;
	localparam mdda_pkg::mdda_op_t MS = mdda_pkg::MDDA_OP_SIGNED_EXTENDED_MULTIPLY;
	localparam mdda_pkg::mdda_op_t DU = mdda_pkg::MDDA_OP_UNSIGNED_EXTENDED_DIVIDE;
	localparam mdda_pkg::mdda_op_t DS = mdda_pkg::MDDA_OP_SIGNED_EXTENDED_DIVIDE;
	localparam mdda_pkg::mdda_op_t DA = mdda_pkg::MDDA_OP_DECIMAL_ADJUST_AFTER_SUBTRACT;
	localparam mdda_pkg::mdda_op_t DL = mdda_pkg::MDDA_OP_LONG_DECREMENT;
	localparam mdda_pkg::mdda_op_t CP = mdda_pkg::MDDA_OP_COMPARE_OP;
	localparam mdda_pkg::mdda_size_t SB = mdda_pkg::MDDA_SZ_BYTE;
	localparam mdda_pkg::mdda_size_t SW = mdda_pkg::MDDA_SZ_WORD;
	localparam mdda_pkg::mdda_size_t SL = mdda_pkg::MDDA_SZ_LONG;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic req_valid = 1'b0;
	mdda_pkg::mdda_req_t req = '0;
	logic busy;
	logic rsp_valid;
	mdda_pkg::mdda_rsp_t rsp;
	mdda_pkg::mdda_rsp_t last;
	logic preset = 1'b0;
	logic [31:0] preset_value = 32'h00000000;
	logic [31:0] dest;
	int err_total = 0;
	int samples_checked = 0;
	always #12.5 clk = ~clk;
	mdda_alu dut (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req), .busy(busy),
		.rsp_valid(rsp_valid), .rsp(rsp));
	mdda_regfile_model partner (.clk(clk), .reset(reset), .preset(preset), .preset_value(preset_value),
		.rsp_valid(rsp_valid), .rsp(rsp), .dest(dest));
	task automatic complete_run;
		if (err_total == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic drive(input mdda_pkg::mdda_op_t o, input mdda_pkg::mdda_size_t s, input logic two,
		input logic [31:0] d, input logic [31:0] sv, input logic h, input logic c);
		req.op = o;
		req.size = s;
		req.dec_two = two;
		req.dst = d;
		req.src = sv;
		req.in_h = h;
		req.in_c = c;
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
	endtask
	// bounded wait: divides answer well inside 40 cycles
	task automatic wait_rsp;
		int n;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (n >= 40) begin
			err_total++;
			complete_run();
		end else begin
			last = rsp;
			@(negedge clk);
		end
	endtask
	task automatic run_op(input mdda_pkg::mdda_op_t o, input mdda_pkg::mdda_size_t s, input logic two,
		input logic [31:0] d, input logic [31:0] sv, input logic h, input logic c);
		drive(o, s, two, d, sv, h, c);
		wait_rsp();
	endtask
	task automatic t_mult;
		run_op(MU, SB, 1'b0, 32'hABCD00FF, 32'h000000FF, 1'b0, 1'b0);
		check("mulu_b", last.result, 32'hABCDFE01);
		run_op(MU, SW, 1'b0, 32'h0000FFFF, 32'h0000FFFF, 1'b0, 1'b0);
		check("mulu_w", last.result, 32'hFFFE0001);
		run_op(MS, SB, 1'b0, 32'h12340080, 32'h0000007F, 1'b0, 1'b0);
		check("muls_b", last.result, 32'h1234C080);
		check("muls_b_n", 32'(last.flags[`MDDA_FLAG_N]), 32'h00000001);
		run_op(MS, SW, 1'b0, 32'h00008000, 32'h0000FFFF, 1'b0, 1'b0);
		check("muls_w", last.result, 32'h00008000);
	endtask
	task automatic t_div;
		run_op(DU, SB, 1'b0, 32'h555503E8, 32'h00000007, 1'b0, 1'b0);
		check("divu_b", last.result, 32'h5555068E);
		run_op(DS, SB, 1'b0, 32'h0000FF9C, 32'h00000007, 1'b0, 1'b0);
		check("divs_b", last.result, 32'h0000FEF2);
		run_op(DS, SW, 1'b0, 32'hFFF0BDC0, 32'h0000FF00, 1'b0, 1'b0);
		check("divs_w", last.result, 32'hFFC00F42);
		run_op(DS, SW, 1'b0, 32'h000F4240, 32'h0000FF00, 1'b0, 1'b0);
		check("divs_w_neg", last.result, 32'h0040F0BE);
		run_op(DU, SB, 1'b0, 32'h00000010, 32'h00000000, 1'b0, 1'b0);
		check("div_zero_z", 32'(last.flags[`MDDA_FLAG_Z]), 32'h00000001);
	endtask
	// a compare sent mid-divide must vanish, not queue behind it
	task automatic t_refuse;
		int k;
		drive(DU, SW, 1'b0, 32'h000F4240, 32'h00000100, 1'b0, 1'b0);
		@(negedge clk);
		check("busy_div", 32'(busy), 32'h00000001);
		drive(CP, SL, 1'b0, 32'h00000001, 32'h00000001, 1'b0, 1'b0);
		wait_rsp();
		check("divu_w", last.result, 32'h00400F42);
		k = 0;
		repeat (4) begin
			if (rsp_valid === 1'b1) k++;
			@(negedge clk);
		end
		check("no_extra_rsp", 32'(k), 32'h00000000);
	endtask
	task automatic t_das;
		logic [7:0] dv[5] = '{8'h2D, 8'hD3, 8'h0F, 8'hFF, 8'h45};
		logic hv[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
		logic cv[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
		logic [7:0] ev[5] = '{8'h27, 8'h73, 8'h09, 8'h99, 8'h45};
		for (int i = 0; i < 5; i++) begin
			run_op(DA, SB, 1'b0, {24'h000000, dv[i]}, 32'h00000000, hv[i], cv[i]);
			check("das", 32'(last.result[7:0]), 32'(ev[i]));
		end
	endtask
	task automatic t_dec;
		run_op(DL, SL, 1'b0, 32'h00000001, 32'h00000000, 1'b0, 1'b0);
		check("dec1", last.result, 32'h00000000);
		run_op(DL, SL, 1'b1, 32'h00000001, 32'h00000000, 1'b0, 1'b0);
		check("dec2_wrap", last.result, 32'hFFFFFFFF);
		run_op(DL, SL, 1'b1, 32'h80000000, 32'h00000000, 1'b0, 1'b0);
		check("dec2_v", last.result, 32'h7FFFFFFE);
		check("dec2_vflag", 32'(last.flags[`MDDA_FLAG_V]), 32'h00000001);
	endtask
	task automatic t_cmp;
		preset_value = 32'h00001234;
		preset = 1'b1;
		@(negedge clk);
		preset = 1'b0;
		run_op(CP, SL, 1'b0, 32'h00001234, 32'h00001234, 1'b0, 1'b0);
		check("cmp_z", 32'(last.flags[`MDDA_FLAG_Z]), 32'h00000001);
		check("cmp_we", 32'(last.write_en), 32'h00000000);
		run_op(CP, SB, 1'b0, 32'h00001201, 32'h00000002, 1'b0, 1'b0);
		check("cmp_c", 32'(last.flags[`MDDA_FLAG_C]), 32'h00000001);
		check("cmp_h", 32'(last.flags[`MDDA_FLAG_H]), 32'h00000001);
		run_op(CP, SW, 1'b0, 32'h00008000, 32'h00000001, 1'b0, 1'b0);
		check("cmp_v", 32'(last.flags[`MDDA_FLAG_V]), 32'h00000001);
		@(negedge clk);
		check("cmp_keep", dest, 32'h00001234);
	endtask
	initial begin
		repeat (20) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		t_mult();
		t_div();
		t_refuse();
		t_das();
		t_dec();
		t_cmp();
		complete_run();
	end
endmodule // multiply_divide_decimal_alu_tb_top
`default_nettype wire
